// ### design/isn_cfg.svh
`ifndef ISN_CFG_SVH
`define ISN_CFG_SVH
// Overview of operation
// [R01] Select byte bits 7:0 hold the host interface code, 0x00 is none, 0x80 the on-chip bus, others reserved.
// [R02] Codes 0x01 to 0x07 pick 4 in, 4 out, 2 in 2 out, digital I/O, serial slave, oversampling, port 3 bridge.
// [R03] Codes 0x08 and 0x09 pick 16-bit and 8-bit asynchronous, 0x0A and 0x0B synchronous controller ports.
// [R04] Codes 0x10 to 0x14 pick 32-pin digital splits 32/0, 24/8, 16/16, 8/24 and 0/32.
// [R05] Config bit 0 low lets the local host set the state register, high mirrors the request register.
// [R06] Mirror bit resets to 0 then loads from word 0, or on the soft core is 1 for digital I/O or the strap, the strap only for controller and bus codes.
// [R07] Config bit 1 high enables enhanced link on all ports, overriding bits 7:4.
// [R08] Config bits 4 to 7 enable enhanced link on ports 0 to 3, a 0 counts only while bit 1 is 0.
// [R09] The enhanced link bits reset to 1 and are later loaded from word 0.
// [R10] Config bit 2 enables the time sync output unit, 0 switches it off to save power.
// [R11] Config bit 3 enables the time latch input unit, 0 switches it off to save power.
// [R12] Enhanced link bits take the stored word only on the first load after reset, later loads keep them.
// [R13] With mirroring on the request register takes network writes at any time and copies them to state.
// [R14] The state register takes local host writes only while mirroring is off.
// [R15] Both configuration registers ignore all writes and change only by reset or loading, but the soft core mirror bit follows [R06] each cycle.
`define ISN_IDX_APP_REQ   12'h120
`define ISN_IDX_APP_STATE 12'h130
`define ISN_IDX_IFSEL     12'h140
`define ISN_IDX_NODECFG   12'h141
`define ISN_A_APP_REQ     12'(`ISN_IDX_APP_REQ << 2)
`define ISN_A_APP_STATE   12'(`ISN_IDX_APP_STATE << 2)
`define ISN_A_IFSEL       12'(`ISN_IDX_IFSEL << 2)
`define ISN_A_NODECFG     12'(`ISN_IDX_NODECFG << 2)
`define ISN_CFG_MIRROR    0
`define ISN_CFG_ELINK_ALL 1
`define ISN_CFG_SYNC_OUT  2
`define ISN_CFG_LATCH_IN  3
`define ISN_CFG_ELINK_LO  4
`define ISN_CFG_ELINK_HI  7
`define ISN_W0_CFG_LO     8
`define ISN_W0_CFG_HI     15
`define ISN_IFSEL_RST     8'h00
`define ISN_CFG_RST       8'hF2
`define ISN_APP_STATE_RST 8'h01
`define ISN_APP_REQ_RST   8'h00
`define ISN_ELINK_ALL_ON  4'hF
`endif

// ### design/isn_pkg.sv
package isn_pkg;
    typedef logic [7:0] isn_byte_t;
    typedef enum logic [7:0] {
        ISN_IF_NONE   = 8'h00, ISN_IF_DIN4  = 8'h01, ISN_IF_DOUT4 = 8'h02,
        ISN_IF_DIO22  = 8'h03, ISN_IF_DIO   = 8'h04, ISN_IF_SPI   = 8'h05,
        ISN_IF_OVS    = 8'h06, ISN_IF_BRIDGE = 8'h07, ISN_IF_AMCU16 = 8'h08,
        ISN_IF_AMCU8  = 8'h09, ISN_IF_SMCU16 = 8'h0A, ISN_IF_SMCU8 = 8'h0B,
        ISN_IF_D32_0  = 8'h10, ISN_IF_D24_8 = 8'h11, ISN_IF_D16_16 = 8'h12,
        ISN_IF_D8_24  = 8'h13, ISN_IF_D0_32 = 8'h14, ISN_IF_BUS   = 8'h80
    } isn_if_e;
    typedef enum logic [2:0] {
        ISN_CL_NONE = 3'b000, ISN_CL_DIGITAL = 3'b001, ISN_CL_SPI = 3'b010,
        ISN_CL_BRIDGE = 3'b011, ISN_CL_MCU = 3'b100, ISN_CL_BUS = 3'b101,
        ISN_CL_RSVD = 3'b110
    } isn_if_class_e;
    typedef enum logic [0:0] {
        ISN_LD_FIRST = 1'b0,
        ISN_LD_LATER = 1'b1
    } isn_ld_e;
endpackage

// ### design/isn_app_if.sv
`timescale 1ns/1ps
interface isn_app_if;
    logic              mirror_on;
    logic              net_wr;
    isn_pkg::isn_byte_t net_data;
    logic              host_wr;
    isn_pkg::isn_byte_t host_data;
    isn_pkg::isn_byte_t app_req;
    isn_pkg::isn_byte_t app_state;
    modport ctrl (output mirror_on, net_wr, net_data, host_wr, host_data,
                  input app_req, app_state);
    modport keep (input mirror_on, net_wr, net_data, host_wr, host_data,
                  output app_req, app_state);
endinterface

// ### design/isn_app_state.sv
`timescale 1ns/1ps
`include "isn_cfg.svh"
module isn_app_state (
    input logic         core_clk,
    input logic         rst_n,
    input logic         clk_en,
    isn_app_if.keep     ai
);
    isn_pkg::isn_byte_t req;
    isn_pkg::isn_byte_t state;
    isn_pkg::isn_byte_t next_req;
    isn_pkg::isn_byte_t next_state;

    always_comb begin
        next_req   = req;
        next_state = state;
        if (ai.host_wr && !ai.mirror_on) begin // [R05] [R14]
            next_state = ai.host_data;
        end
        if (ai.net_wr) begin
            next_req = ai.net_data;
            if (ai.mirror_on) begin // [R05] [R13]
                next_state = ai.net_data;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            req   <= `ISN_APP_REQ_RST;
            state <= `ISN_APP_STATE_RST;
        end else if (clk_en) begin
            req   <= next_req;
            state <= next_state;
        end
    end

    assign ai.app_req   = req;
    assign ai.app_state = state;

    a_mirror_copy: assert property ( // [R13]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && ai.mirror_on && ai.net_wr |=> state == $past(ai.net_data))
        else $error("Mirrored request not copied to state.");

    a_host_blocked: assert property ( // [R14]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && ai.mirror_on && ai.host_wr && !ai.net_wr |=> $stable(state))
        else $error("Host write reached state while mirroring.");

    a_host_write: assert property ( // [R05]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && !ai.mirror_on && ai.host_wr |=> state == $past(ai.host_data))
        else $error("Host write to state lost.");
endmodule // isn_app_state

// ### design/isn_regs.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "isn_cfg.svh"
module isn_regs #(
    parameter bit        SOFT_CORE     = 1'b0,
    parameter logic [7:0] SOFT_IFSEL   = 8'h80,
    parameter bit        SOFT_SYNC_OUT = 1'b1,
    parameter bit        SOFT_LATCH_IN = 1'b1
) (
    input  logic        core_clk,
    input  logic        rst_n,
    input  logic        clk_en,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        eeprom_load,
    input  logic [15:0] eeprom_word0,
    input  logic        state_mirror_strap,
    input  logic        net_app_req_wr,
    input  logic [7:0]  net_app_req_data,
    output logic [7:0]  host_if_select,
    output logic [7:0]  node_config,
    output logic [2:0]  if_class,
    output logic [3:0]  elink_en,
    output logic        sync_out_en,
    output logic        latch_in_en,
    output logic        config_loaded,
    output logic [7:0]  app_state,
    output logic [7:0]  app_request
);
    localparam logic [7:0] IFSEL_RST = SOFT_CORE ? SOFT_IFSEL : `ISN_IFSEL_RST;
    localparam logic [7:0] CFG_RST   = SOFT_CORE ?
        {4'hF, SOFT_LATCH_IN, SOFT_SYNC_OUT, 2'b10} : `ISN_CFG_RST;

    isn_app_if ai ();

    isn_app_state u_app_state (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .ai       (ai.keep)
    );

    function automatic isn_pkg::isn_if_class_e class_of(input logic [7:0] code);
        case (code)
            isn_pkg::ISN_IF_NONE:   class_of = isn_pkg::ISN_CL_NONE;
            isn_pkg::ISN_IF_DIN4,
            isn_pkg::ISN_IF_DOUT4,
            isn_pkg::ISN_IF_DIO22,
            isn_pkg::ISN_IF_DIO,
            isn_pkg::ISN_IF_OVS:    class_of = isn_pkg::ISN_CL_DIGITAL; // [R02]
            isn_pkg::ISN_IF_SPI:    class_of = isn_pkg::ISN_CL_SPI; // [R02]
            isn_pkg::ISN_IF_BRIDGE: class_of = isn_pkg::ISN_CL_BRIDGE; // [R02]
            isn_pkg::ISN_IF_AMCU16,
            isn_pkg::ISN_IF_AMCU8,
            isn_pkg::ISN_IF_SMCU16,
            isn_pkg::ISN_IF_SMCU8:  class_of = isn_pkg::ISN_CL_MCU; // [R03]
            isn_pkg::ISN_IF_D32_0,
            isn_pkg::ISN_IF_D24_8,
            isn_pkg::ISN_IF_D16_16,
            isn_pkg::ISN_IF_D8_24,
            isn_pkg::ISN_IF_D0_32:  class_of = isn_pkg::ISN_CL_DIGITAL; // [R04]
            isn_pkg::ISN_IF_BUS:    class_of = isn_pkg::ISN_CL_BUS; // [R01]
            default:                class_of = isn_pkg::ISN_CL_RSVD; // [R01]
        endcase
    endfunction

    // Strap synchroniser: the level counts once stages two and three agree.
    logic strap_s1;
    logic strap_s2;
    logic strap_s3;
    logic strap_q;
    logic next_strap_s1;
    logic next_strap_s2;
    logic next_strap_s3;
    logic next_strap_q;

    always_comb begin
        next_strap_s1 = state_mirror_strap;
        next_strap_s2 = strap_s1;
        next_strap_s3 = strap_s2;
        next_strap_q  = strap_q;
        if (strap_s2 == strap_s3) begin
            next_strap_q = strap_s3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_s3 <= 1'b0;
            strap_q  <= 1'b0;
        end else if (clk_en) begin
            strap_s1 <= next_strap_s1;
            strap_s2 <= next_strap_s2;
            strap_s3 <= next_strap_s3;
            strap_q  <= next_strap_q;
        end
    end

    // Configuration registers, written by reset and loading, and on the soft core the mirror bit each cycle.
    logic [7:0]       ifsel;
    logic [7:0]       cfg;
    isn_pkg::isn_ld_e ld;
    logic             loaded;
    logic [7:0]       next_ifsel;
    logic [7:0]       next_cfg;
    isn_pkg::isn_ld_e next_ld;
    logic             next_loaded;
    logic [7:0]       w0_cfg;
    isn_pkg::isn_if_class_e cur_class;
    logic             soft_mirror;

    assign w0_cfg    = eeprom_word0[`ISN_W0_CFG_HI:`ISN_W0_CFG_LO];
    assign cur_class = class_of(ifsel);

    always_comb begin
        case (cur_class)
            isn_pkg::ISN_CL_DIGITAL: soft_mirror = 1'b1; // [R06]
            isn_pkg::ISN_CL_MCU,
            isn_pkg::ISN_CL_BUS:     soft_mirror = strap_q; // [R06]
            default:                 soft_mirror = 1'b0;
        endcase
    end

    always_comb begin
        next_ifsel  = ifsel;
        next_cfg    = cfg;
        next_ld     = ld;
        next_loaded = loaded;
        if (eeprom_load) begin
            next_loaded = 1'b1;
            if (!SOFT_CORE) begin
                next_ifsel = eeprom_word0[7:0]; // [R01]
                next_cfg[`ISN_CFG_MIRROR]   = w0_cfg[`ISN_CFG_MIRROR]; // [R06]
                next_cfg[`ISN_CFG_SYNC_OUT] = w0_cfg[`ISN_CFG_SYNC_OUT]; // [R10]
                next_cfg[`ISN_CFG_LATCH_IN] = w0_cfg[`ISN_CFG_LATCH_IN]; // [R11]
            end
            case (ld)
                isn_pkg::ISN_LD_FIRST: begin
                    next_cfg[`ISN_CFG_ELINK_ALL] = w0_cfg[`ISN_CFG_ELINK_ALL]; // [R12]
                    next_cfg[`ISN_CFG_ELINK_HI:`ISN_CFG_ELINK_LO] =
                        w0_cfg[`ISN_CFG_ELINK_HI:`ISN_CFG_ELINK_LO]; // [R09] [R12]
                    next_ld = isn_pkg::ISN_LD_LATER;
                end
                isn_pkg::ISN_LD_LATER: begin
                    next_ld = isn_pkg::ISN_LD_LATER; // [R12]
                end
                default: begin
                    next_ld = isn_pkg::ISN_LD_FIRST;
                end
            endcase
        end
        if (SOFT_CORE) begin
            next_cfg[`ISN_CFG_MIRROR] = soft_mirror; // [R06]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ifsel  <= IFSEL_RST;
            cfg    <= CFG_RST; // [R06] [R09]
            ld     <= isn_pkg::ISN_LD_FIRST;
            loaded <= 1'b0;
        end else if (clk_en) begin
            ifsel  <= next_ifsel;
            cfg    <= next_cfg;
            ld     <= next_ld;
            loaded <= next_loaded;
        end
    end

    // Registered decode of the configuration towards the other units.
    logic [3:0] elink_calc;
    logic [3:0] next_elink;
    logic       next_sync;
    logic       next_latch;
    logic [2:0] next_class;

    for (genvar gi = 0; gi < 4; gi++) begin : g_elink
        assign elink_calc[gi] = cfg[`ISN_CFG_ELINK_ALL] | cfg[`ISN_CFG_ELINK_LO + gi]; // [R07] [R08]
    end

    always_comb begin
        next_elink = elink_calc;
        next_sync  = cfg[`ISN_CFG_SYNC_OUT]; // [R10]
        next_latch = cfg[`ISN_CFG_LATCH_IN]; // [R11]
        next_class = cur_class;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            elink_en    <= `ISN_ELINK_ALL_ON;
            sync_out_en <= 1'b0;
            latch_in_en <= 1'b0;
            if_class    <= isn_pkg::ISN_CL_NONE;
        end else if (clk_en) begin
            elink_en    <= next_elink;
            sync_out_en <= next_sync;
            latch_in_en <= next_latch;
            if_class    <= next_class;
        end
    end

    assign host_if_select = ifsel;
    assign node_config    = cfg;
    assign config_loaded  = loaded;
    assign app_state      = ai.app_state;
    assign app_request    = ai.app_req;

    // APB slave: no wait state, data and error registered in the setup cycle.
    logic        acc;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] next_prdata;

    assign acc = psel && penable && pready;

    always_comb begin
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        if (psel && !penable) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            case (paddr)
                `ISN_A_APP_REQ:   next_prdata[7:0] = ai.app_req;
                `ISN_A_APP_STATE: next_prdata[7:0] = ai.app_state;
                `ISN_A_IFSEL:     next_prdata[7:0] = ifsel;
                `ISN_A_NODECFG:   next_prdata[7:0] = cfg;
                default:          next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // Writes to the select and config words are dropped without error.
    assign ai.mirror_on = cfg[`ISN_CFG_MIRROR];
    assign ai.net_wr    = net_app_req_wr; // [R13]
    assign ai.net_data  = net_app_req_data;
    assign ai.host_wr   = acc && pwrite && (paddr == `ISN_A_APP_STATE); // [R14] [R15]
    assign ai.host_data = pwdata[7:0];

    a_ifsel_ro_write: assert property ( // [R15]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && acc && pwrite && !eeprom_load |=> $stable(host_if_select))
        else $error("Select byte changed by a bus write.");

    a_cfg_ro_write: assert property ( // [R15]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && acc && pwrite && !eeprom_load && !SOFT_CORE |=> $stable(node_config))
        else $error("Config byte changed by a bus write.");

    a_first_load_elink: assert property ( // [R12]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && eeprom_load && ld == isn_pkg::ISN_LD_FIRST |=>
        node_config[7:4] == $past(eeprom_word0[15:12]) &&
        node_config[1] == $past(eeprom_word0[9]))
        else $error("First load did not copy link bits.");

    a_later_load_keep: assert property ( // [R12]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && eeprom_load && ld == isn_pkg::ISN_LD_LATER |=>
        $stable(node_config[7:4]) && $stable(node_config[1]))
        else $error("Later load changed link bits.");

    a_elink_decode: assert property ( // [R07]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en |=> elink_en == ($past(node_config[1]) ? 4'hF : $past(node_config[7:4])))
        else $error("Enhanced link enables wrong.");

    a_unit_enables: assert property ( // [R10]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en |=> sync_out_en == $past(node_config[2]) &&
        latch_in_en == $past(node_config[3]))
        else $error("Sync or latch enable wrong.");

    a_reset_defaults: assert property ( // [R09]
        @(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> node_config[7:4] == 4'hF && node_config[1] &&
        (SOFT_CORE || !node_config[0]) && !config_loaded)
        else $error("Config reset values wrong.");

    a_ifsel_load: assert property ( // [R01]
        @(posedge core_clk) disable iff (!rst_n)
        !SOFT_CORE && clk_en && eeprom_load |=> host_if_select == $past(eeprom_word0[7:0]))
        else $error("Select byte not loaded.");

    a_apb_answer: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && psel && !penable |=> pready ##1 !pready)
        else $error("Bus answer timing wrong.");

    a_class_bus: assert property ( // [R01]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && host_if_select == 8'h80 |=> if_class == isn_pkg::ISN_CL_BUS)
        else $error("On-chip bus select not decoded.");

    a_class_rsvd: assert property ( // [R01]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && host_if_select > 8'h14 && host_if_select != 8'h80 |=>
        if_class == isn_pkg::ISN_CL_RSVD)
        else $error("Reserved select not decoded.");

    a_class_spi: assert property ( // [R02]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && host_if_select == 8'h05 |=> if_class == isn_pkg::ISN_CL_SPI)
        else $error("Serial slave select not decoded.");

    a_class_mcu: assert property ( // [R03]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && host_if_select >= 8'h08 && host_if_select <= 8'h0B |=>
        if_class == isn_pkg::ISN_CL_MCU)
        else $error("Controller port select not decoded.");

    a_class_split: assert property ( // [R04]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && host_if_select >= 8'h10 && host_if_select <= 8'h14 |=>
        if_class == isn_pkg::ISN_CL_DIGITAL)
        else $error("Pin split select not decoded.");

    a_mirror_load: assert property ( // [R06]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && eeprom_load && !SOFT_CORE |=> node_config[0] == $past(eeprom_word0[8]))
        else $error("Mirror bit not loaded.");

    a_unit_bits_load: assert property ( // [R10] [R11]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && eeprom_load && !SOFT_CORE |=>
        node_config[3:2] == $past(eeprom_word0[11:10]))
        else $error("Sync or latch bit not loaded.");

    a_loaded_flag: assert property ( // [R12]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && eeprom_load |=> config_loaded)
        else $error("Load flag not set by a load.");

    a_strap_agree: assert property ( // [R06]
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && strap_s2 == strap_s3 |=> strap_q == $past(strap_s3))
        else $error("Strap level not taken once stages agreed.");
endmodule // isn_regs

// ### tb/isn_far_side.sv
`timescale 1ns/1ps
module isn_far_side (
    input  logic        core_clk,
    output logic        eeprom_load,
    output logic [15:0] eeprom_word0,
    output logic        net_app_req_wr,
    output logic [7:0]  net_app_req_data
);
    initial begin
        eeprom_load = 1'b0;
        eeprom_word0 = 16'h0000;
        net_app_req_wr = 1'b0;
        net_app_req_data = 8'h00;
    end

    // Word 0 is valid for the single cycle of the load pulse only.
    task automatic load_word(input logic [15:0] w);
        @(posedge core_clk);
        eeprom_load <= 1'b1;
        eeprom_word0 <= w;
        @(posedge core_clk);
        eeprom_load <= 1'b0;
        eeprom_word0 <= ~w;
    endtask

    // Data for the request register is not held past its pulse.
    task automatic net_write(input logic [7:0] d);
        @(posedge core_clk);
        net_app_req_wr <= 1'b1;
        net_app_req_data <= d;
        @(posedge core_clk);
        net_app_req_wr <= 1'b0;
        net_app_req_data <= ~d;
    endtask
endmodule // isn_far_side

// ### tb/isn_regs_tb.sv
`timescale 1ns/1ps
`include "isn_cfg.svh"
module isn_regs_tb;
    logic        core_clk;
    logic        rst_n;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        eeprom_load;
    logic [15:0] eeprom_word0;
    logic        state_mirror_strap;
    logic        net_app_req_wr;
    logic [7:0]  net_app_req_data;
    logic [7:0]  host_if_select;
    logic [7:0]  node_config;
    logic [2:0]  if_class;
    logic [3:0]  elink_en;
    logic        sync_out_en;
    logic        latch_in_en;
    logic        config_loaded;
    logic [7:0]  app_state;
    logic [7:0]  app_request;
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [15:0] seed;
    logic [7:0]  m_ifsel, m_cfg, m_state, m_req;
    logic        m_loaded;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  codes [20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h09, 8'h0A, 8'h0B, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h80, 8'h0C, 8'h7F};

    isn_regs isn_regs_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eeprom_load(eeprom_load),
        .eeprom_word0(eeprom_word0), .state_mirror_strap(state_mirror_strap),
        .net_app_req_wr(net_app_req_wr), .net_app_req_data(net_app_req_data),
        .host_if_select(host_if_select), .node_config(node_config), .if_class(if_class),
        .elink_en(elink_en), .sync_out_en(sync_out_en), .latch_in_en(latch_in_en),
        .config_loaded(config_loaded), .app_state(app_state), .app_request(app_request));

    isn_far_side isn_far_side_i (.core_clk(core_clk), .eeprom_load(eeprom_load),
        .eeprom_word0(eeprom_word0), .net_app_req_wr(net_app_req_wr),
        .net_app_req_data(net_app_req_data));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    function automatic logic [2:0] cls(input logic [7:0] c);
        if (c == 8'h00) return 3'h0;
        if (c == 8'h05) return 3'h2;
        if (c == 8'h07) return 3'h3;
        if (c >= 8'h08 && c <= 8'h0B) return 3'h4;
        if (c == 8'h80) return 3'h5;
        if ((c >= 8'h01 && c <= 8'h06) || (c >= 8'h10 && c <= 8'h14)) return 3'h1;
        return 3'h6;
    endfunction

    function automatic void next_rand();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, 32'(exp));
        check("read error", 32'(err), 32'h0);
    endtask

    task automatic verify;
        check("host_if_select", 32'(host_if_select), 32'(m_ifsel));
        check("if_class", 32'(if_class), 32'(cls(m_ifsel)));
        check("node_config", 32'(node_config), 32'(m_cfg));
        check("elink_en", 32'(elink_en), 32'({4{m_cfg[1]}} | m_cfg[7:4]));
        check("sync_out_en", 32'(sync_out_en), 32'(m_cfg[2]));
        check("latch_in_en", 32'(latch_in_en), 32'(m_cfg[3]));
        check("config_loaded", 32'(config_loaded), 32'(m_loaded));
        check("app_state", 32'(app_state), 32'(m_state));
        check("app_request", 32'(app_request), 32'(m_req));
        rd_chk("read select", `ISN_A_IFSEL, m_ifsel);
        rd_chk("read config", `ISN_A_NODECFG, m_cfg);
        rd_chk("read state", `ISN_A_APP_STATE, m_state);
        rd_chk("read request", `ISN_A_APP_REQ, m_req);
    endtask

    task automatic load(input logic [15:0] w);
        isn_far_side_i.load_word(w);
        if (!m_loaded) m_cfg = w[15:8];
        else m_cfg = {m_cfg[7:4], w[11:10], m_cfg[1], w[8]};
        m_ifsel = w[7:0];
        m_loaded = 1'b1;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic net_wr(input logic [7:0] d);
        isn_far_side_i.net_write(d);
        m_req = d;
        if (m_cfg[0]) m_state = d;
        @(posedge core_clk);
    endtask

    task automatic host_wr(input logic [7:0] d);
        apb(1'b1, `ISN_A_APP_STATE, 32'(d));
        if (!m_cfg[0]) m_state = d;
        @(posedge core_clk);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        m_ifsel = 8'h00;
        m_cfg = 8'hF2;
        m_state = 8'h01;
        m_req = 8'h00;
        m_loaded = 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        seed = 16'd33273;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        clk_en = 1'b1;
        state_mirror_strap = 1'b0;
        do_reset();
        verify();
        $display("test reset values done");
        apb(1'b1, `ISN_A_IFSEL, 32'h000000FF);
        check("write select error", 32'(err), 32'h0);
        apb(1'b1, `ISN_A_NODECFG, 32'h0000000D);
        apb(1'b0, 12'h600, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        host_wr(8'h5A);
        verify();
        $display("test write refusal done");
        next_rand();
        load({(seed[15:8] & 8'hFD) | 8'h01, 8'h80});
        next_rand();
        net_wr(seed[7:0]);
        host_wr(~seed[7:0]);
        verify();
        $display("test first load done");
        clk_en <= 1'b0;
        isn_far_side_i.load_word(16'h0000);
        isn_far_side_i.net_write(8'hA5);
        clk_en <= 1'b1;
        verify();
        $display("test clock enable freeze done");
        for (int i = 0; i < 20; i++) begin
            next_rand();
            load({seed[15:8], codes[i]});
            net_wr(seed[7:0]);
            host_wr(seed[15:8]);
            verify();
        end
        load(16'h0004);
        host_wr(8'hC3);
        net_wr(8'h3C);
        verify();
        $display("test select codes done");
        do_reset();
        verify();
        load(16'h0C11);
        verify();
        load(16'hF311);
        verify();
        $display("test reload after reset done");
        results();
    end
endmodule // isn_regs_tb
